//--- sdc_map.vh
// Constants for the service diagnostic controller
`ifndef SDC_MAP_VH
`define SDC_MAP_VH
// Register offsets
`define SDC_REG_CTRL      4'h0
`define SDC_REG_ACT       4'h1
`define SDC_REG_STATUS    4'h2
`define SDC_REG_FAULT     4'h3
`define SDC_REG_SIZE      4'h4
`define SDC_REG_MODE      4'h5
// Control register fields
`define SDC_CTRL_RETRY    0
`define SDC_CTRL_REPEAT   1
// Reset values
`define SDC_CTRL_RST      2'h1
// Timing, in seconds, milliseconds, hertz and clock cycles
`define SDC_HEAT_S        8'd60
`define SDC_COOL_S        8'd180
`define SDC_RETRY_S       16'd480
`define SDC_STORE_MS      32'd2000
`define SDC_BEEP_MS       32'd100
`define SDC_FLASH_MS      32'd500
`define SDC_PUMP_HZ       32'd50
`define SDC_CLK_HZ        32'd100000000
`define SDC_SEC_CYC       (`SDC_CLK_HZ)
`define SDC_MS_CYC        (`SDC_CLK_HZ / 32'd1000)
`define SDC_PUMP_HALF_CYC (`SDC_CLK_HZ / (`SDC_PUMP_HZ * 32'd2))
// Fault code and spin limits
`define SDC_FAULT_NOSIZE  8'h09
`define SDC_RPM_FULL      11'd1000
`define SDC_RPM_WARM      11'd700
// Size codes
`define SDC_SIZE_NONE     3'h0
`define SDC_SIZE_A        3'h1
`define SDC_SIZE_B        3'h2
`define SDC_SIZE_C        3'h3
// Screens
`define SDC_SCR_BLANK     3'h0
`define SDC_SCR_MACHINE   3'h1
`define SDC_SCR_FAULT     3'h2
`define SDC_SCR_OPTION    3'h3
`define SDC_SCR_SIZE      3'h4
`define SDC_SCR_NORMAL    3'h5
`endif

//--- sdc_ctrl.v
// Service diagnostic controller: front panel, actuators, flags and register port
`timescale 1ns/1ns
`include "sdc_map.vh"
module sdc_ctrl #(
  parameter SEC_CYC   = `SDC_SEC_CYC,
  parameter MS_CYC    = `SDC_MS_CYC,
  parameter PUMP_HALF = `SDC_PUMP_HALF_CYC
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Front panel buttons, levels
  input  wire        i_btn_power,
  input  wire        i_btn_fabric,
  input  wire        i_btn_eco_cycle,
  input  wire        i_btn_option,
  input  wire        i_btn_soil_down,
  input  wire        i_btn_soil_up,
  input  wire [3:0]  i_btn_side,
  // Sensors and cycle events
  input  wire        i_lid_open,
  input  wire        i_imbalance_switch,
  input  wire [7:0]  i_temp_c,
  input  wire        i_fault_det,
  input  wire        i_fault_clr,
  input  wire [7:0]  i_fault_code,
  input  wire [2:0]  i_cycle_phase,
  input  wire        i_cycle_end,
  input  wire        i_hot_fill,
  input  wire        i_final_rinse,
  input  wire        i_nv_size_ok,
  input  wire [2:0]  i_nv_size,
  input  wire [1:0]  i_nv_flags,
  // Register port
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  // Display fields
  output reg  [2:0]  o_screen,
  output reg         o_valve_heating,
  output reg         o_valve_cooling,
  output reg  [7:0]  o_valve_count,
  output reg  [7:0]  o_shown_fault,
  output reg  [3:0]  o_select_hl,
  // Actuators and indicators
  output reg         o_pump_drive,
  output reg         o_cold_valve,
  output reg         o_hot_valve,
  output reg         o_recirc_valve,
  output reg         o_beep,
  output reg  [4:0]  o_soil_leds,
  output reg  [4:0]  o_fabric_leds,
  output reg  [10:0] o_max_rpm,
  output reg         o_rerun_cycle,
  output reg         o_restart_req,
  output reg         o_nv_store,
  output reg  [1:0]  o_nv_flags,
  output reg         o_size_store,
  output reg  [2:0]  o_size_val
);

  // ========================================================
  // Edge detection and time bases
  // ========================================================
  reg  [7:0]  btn_q_r;
  wire [7:0]  btn_now = {i_btn_side, i_btn_option, i_btn_eco_cycle,
                         i_btn_fabric, i_btn_power};
  wire [7:0]  btn_rise = btn_now & ~btn_q_r;
  reg  [31:0] sec_cnt_r;
  reg  [31:0] ms_cnt_r;
  wire        sec_tick = (sec_cnt_r == SEC_CYC - 1);
  wire        ms_tick  = (ms_cnt_r == MS_CYC - 1);

  always @(posedge i_clk) begin
    if (i_rst) begin
      btn_q_r   <= 8'h00;
      sec_cnt_r <= 32'h0;
      ms_cnt_r  <= 32'h0;
    end else begin
      btn_q_r   <= btn_now;
      sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
      ms_cnt_r  <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
    end
  end

  // ========================================================
  // Mode state
  // ========================================================
  localparam ST_OFF   = 3'h0;
  localparam ST_BEEP  = 3'h1;
  localparam ST_DIAG  = 3'h2;
  localparam ST_SIZE  = 3'h3;
  localparam ST_RUN   = 3'h4;

  reg  [2:0]  state_r;
  reg  [2:0]  beeps_r;     // Beep half-periods left
  reg  [31:0] bms_r;       // Millisecond timer for beeps and flashing
  reg         flash_r;
  reg  [1:0]  flags_r;     // Retry and repeat-cycle
  reg         warm_r;
  reg  [31:0] hold_ms_r;   // Hold timer for the side button store
  reg         stored_r;
  reg         pump_on_r;
  reg  [31:0] pump_cnt_r;
  reg         valve_cmd_r;
  reg  [7:0]  vcount_r;
  reg  [7:0]  fault_code_r;
  reg  [7:0]  fault_ago_r;
  reg  [2:0]  fault_phase_r;
  reg         fault_shown_r;
  reg  [15:0] retry_s_r;
  reg         retrying_r;
  reg  [2:0]  size_sel_r;
  reg         pwr_on_show_r;

  wire        side_any = |btn_rise[7:4];

  always @(posedge i_clk) begin
    if (i_rst) begin
      state_r       <= ST_OFF;
      beeps_r       <= 3'h0;
      bms_r         <= 32'h0;
      flash_r       <= 1'b0;
      flags_r       <= `SDC_CTRL_RST;
      warm_r        <= 1'b0;
      hold_ms_r     <= 32'h0;
      stored_r      <= 1'b0;
      pump_on_r     <= 1'b0;
      pump_cnt_r    <= 32'h0;
      valve_cmd_r   <= 1'b0;
      vcount_r      <= 8'h00;
      fault_code_r  <= 8'h00;
      fault_ago_r   <= 8'h00;
      fault_phase_r <= 3'h0;
      fault_shown_r <= 1'b0;
      retry_s_r     <= 16'h0;
      retrying_r    <= 1'b0;
      size_sel_r    <= `SDC_SIZE_NONE;
      pwr_on_show_r <= 1'b0;
      o_screen      <= `SDC_SCR_BLANK;
      o_select_hl   <= 4'h0;
      o_beep        <= 1'b0;
      o_nv_store    <= 1'b0;
      o_size_store  <= 1'b0;
      o_restart_req <= 1'b0;
    end else begin
      o_nv_store    <= 1'b0;
      o_size_store  <= 1'b0;
      o_restart_req <= 1'b0;
      // Beep and flash timebase
      if (ms_tick) begin
        bms_r <= bms_r + 32'h1;
        if (bms_r >= `SDC_BEEP_MS - 32'h1 && beeps_r != 3'h0) begin
          beeps_r <= beeps_r - 3'h1;
          bms_r   <= 32'h0;
        end else if (bms_r >= `SDC_FLASH_MS - 32'h1) begin
          flash_r <= ~flash_r;
          bms_r   <= 32'h0;
        end
      end
      case (state_r)
        ST_OFF: begin
          o_screen <= `SDC_SCR_BLANK;
          if (btn_rise[0] && i_btn_eco_cycle) begin
            state_r <= ST_BEEP;
            beeps_r <= 3'h4;
            bms_r   <= 32'h0;
          end else if (btn_rise[0] && i_btn_fabric) begin
            state_r    <= ST_SIZE;
            o_screen   <= `SDC_SCR_SIZE;
            size_sel_r <= i_nv_size;
          end else if (btn_rise[0]) begin
            state_r       <= ST_RUN;
            o_screen      <= `SDC_SCR_NORMAL;
            pwr_on_show_r <= 1'b1;
            flags_r       <= i_nv_flags;
          end
        end
        ST_BEEP: begin
          // Buttons still held after beeps leave the mode
          if (beeps_r == 3'h0)
            state_r <= (i_btn_eco_cycle | i_btn_power) ? ST_OFF : ST_DIAG;
        end
        ST_DIAG, ST_RUN: begin
          if (btn_rise[0]) begin
            state_r   <= ST_OFF;
            pump_on_r <= 1'b0;
          end
          if (state_r == ST_DIAG) begin
            // Status screen cycling by eco button and side buttons
            if (btn_rise[2])
              o_screen <= `SDC_SCR_MACHINE;
            if (btn_rise[3])
              o_screen <= `SDC_SCR_OPTION;
            else if (side_any && o_screen != `SDC_SCR_OPTION)
              o_screen <= (o_screen == `SDC_SCR_MACHINE) ? `SDC_SCR_FAULT
                                                         : `SDC_SCR_MACHINE;
            if (btn_rise[1])
              pump_on_r <= ~pump_on_r;
            if (o_screen == `SDC_SCR_OPTION) begin
              if (btn_rise[4])
                flags_r[`SDC_CTRL_RETRY] <= ~flags_r[`SDC_CTRL_RETRY];
              if (btn_rise[5])
                flags_r[`SDC_CTRL_REPEAT] <= ~flags_r[`SDC_CTRL_REPEAT];
            end
            if (o_screen == `SDC_SCR_MACHINE && btn_rise[7])
              valve_cmd_r <= ~valve_cmd_r;
            if (i_btn_side[0] && ms_tick && !stored_r) begin
              hold_ms_r <= hold_ms_r + 32'h1;
              if (hold_ms_r == `SDC_STORE_MS - 32'h1) begin
                o_nv_store <= 1'b1;
                stored_r   <= 1'b1;
                beeps_r    <= 3'h2;
                bms_r      <= 32'h0;
              end
            end else if (!i_btn_side[0]) begin
              hold_ms_r <= 32'h0;
              stored_r  <= 1'b0;
            end
          end
          if (btn_rise[1] || btn_rise[2])
            pwr_on_show_r <= 1'b0;
        end
        ST_SIZE: begin
          if (side_any)
            size_sel_r <= btn_rise[4] ? 3'h1 : btn_rise[5] ? 3'h2 : btn_rise[6] ? 3'h3 : 3'h0;
          if (btn_rise[0]) begin
            o_size_store <= 1'b1;
            state_r      <= ST_OFF;
          end
        end
        default: state_r <= ST_OFF;
      endcase
      o_select_hl <= (state_r == ST_SIZE) ? (4'h1 << size_sel_r)
                                          : {2'h0, flags_r};
      if (btn_rise[7] && state_r == ST_DIAG && o_screen == `SDC_SCR_MACHINE)
        vcount_r <= valve_cmd_r ? `SDC_COOL_S : `SDC_HEAT_S;
      else if (sec_tick && vcount_r != 8'h00)
        vcount_r <= vcount_r - 8'h01;
      // A clear in the cycle of a new fault must not hide it, so it goes first
      if (i_fault_clr && !retrying_r)
        fault_shown_r <= 1'b0;
      if (!i_nv_size_ok && state_r == ST_RUN && fault_code_r != `SDC_FAULT_NOSIZE) begin
        fault_code_r  <= `SDC_FAULT_NOSIZE;
        fault_ago_r   <= 8'h00;
        fault_phase_r <= i_cycle_phase;
        fault_shown_r <= 1'b1;
      end else if (i_fault_det && !retrying_r && !fault_shown_r) begin
        fault_code_r  <= i_fault_code;
        fault_ago_r   <= 8'h00;
        fault_phase_r <= i_cycle_phase;
        fault_shown_r <= ~flags_r[`SDC_CTRL_RETRY];
        retrying_r    <= flags_r[`SDC_CTRL_RETRY];
        retry_s_r     <= 16'h0;
      end else if (i_cycle_end && fault_ago_r != 8'hff)
        fault_ago_r <= fault_ago_r + 8'h01;
      if (retrying_r) begin
        o_restart_req <= sec_tick;
        if (i_fault_clr)
          retrying_r <= 1'b0;
        else if (sec_tick) begin
          retry_s_r <= retry_s_r + 16'h1;
          if (retry_s_r == `SDC_RETRY_S - 16'h1) begin
            retrying_r    <= 1'b0;
            fault_shown_r <= 1'b1;
          end
        end
      end
      if (i_hot_fill)
        warm_r <= 1'b1;
      else if (i_final_rinse || (state_r == ST_DIAG && o_screen == `SDC_SCR_OPTION
                                 && btn_rise[6]))
        warm_r <= 1'b0;
      o_beep <= fault_shown_r | beeps_r[0];
      // plain 50 Hz drive, no 10 s cycling
      if (pump_on_r && state_r == ST_DIAG)
        pump_cnt_r <= (pump_cnt_r == PUMP_HALF - 1) ? 32'h0 : pump_cnt_r + 32'h1;
      else
        pump_cnt_r <= 32'h0;
    end
  end

  // ========================================================
  // Registered outputs
  // ========================================================
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_pump_drive    <= 1'b0;
      o_cold_valve    <= 1'b0;
      o_hot_valve     <= 1'b0;
      o_recirc_valve  <= 1'b0;
      o_valve_heating <= 1'b0;
      o_valve_cooling <= 1'b0;
      o_valve_count   <= 8'h00;
      o_shown_fault   <= 8'h00;
      o_soil_leds     <= 5'h00;
      o_fabric_leds   <= 5'h00;
      o_max_rpm       <= `SDC_RPM_FULL;
      o_rerun_cycle   <= 1'b0;
      o_nv_flags      <= `SDC_CTRL_RST;
      o_size_val      <= `SDC_SIZE_NONE;
    end else begin
      if (!pump_on_r || state_r != ST_DIAG)
        o_pump_drive <= 1'b0;
      else if (pump_cnt_r == PUMP_HALF - 1)
        o_pump_drive <= ~o_pump_drive;
      o_cold_valve    <= (state_r == ST_DIAG) & i_btn_soil_down;
      o_hot_valve     <= (state_r == ST_DIAG) & i_btn_soil_up & ~i_btn_soil_down;
      o_recirc_valve  <= valve_cmd_r;
      o_valve_heating <= valve_cmd_r & (vcount_r != 8'h00);
      o_valve_cooling <= ~valve_cmd_r & (vcount_r != 8'h00);
      o_valve_count   <= vcount_r;
      o_shown_fault   <= fault_shown_r ? fault_code_r : 8'h00;
      o_soil_leds     <= (state_r == ST_RUN && !flags_r[`SDC_CTRL_RETRY] && flash_r)
                         ? 5'h1f : 5'h00;
      o_fabric_leds   <= (pwr_on_show_r && flags_r[`SDC_CTRL_REPEAT] && flash_r)
                         ? 5'h1f : 5'h00;
      o_max_rpm       <= warm_r ? `SDC_RPM_WARM : `SDC_RPM_FULL;
      o_rerun_cycle   <= flags_r[`SDC_CTRL_REPEAT] & i_cycle_end;
      o_nv_flags      <= flags_r;
      o_size_val      <= size_sel_r;
    end
  end

  // ========================================================
  // Register read port; every register is read-only, so writes are ignored
  // ========================================================
  always @(posedge i_clk) begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else if (i_rd) begin
      case (i_addr)
        `SDC_REG_CTRL:   o_rdata <= {13'h0, warm_r, flags_r};
        `SDC_REG_ACT:    o_rdata <= {12'h0, valve_cmd_r, o_hot_valve, o_cold_valve, pump_on_r};
        `SDC_REG_STATUS: o_rdata <= {6'h0, i_imbalance_switch, i_lid_open, i_temp_c};
        `SDC_REG_FAULT:  o_rdata <= {fault_phase_r, fault_ago_r[4:0], fault_code_r};
        `SDC_REG_SIZE:   o_rdata <= {5'h0, vcount_r, i_nv_size};
        `SDC_REG_MODE:   o_rdata <= {10'h0, o_screen, state_r};
        default:         o_rdata <= 16'h0000;
      endcase
    end else
      o_rdata <= 16'h0000;
  end

endmodule // sdc_ctrl

//--- sdc_chk_assertions.sv
// Port assertions for the service diagnostic controller
`timescale 1ns/1ns
// ==========================================
// Checker
module sdc_chk #(
  parameter SEC_CYC   = 100,
  parameter PUMP_HALF = 5
) (
  // Clock and reset
  input wire        i_clk,
  input wire        i_rst,
  // Watched inputs
  input wire        i_rd,
  input wire [3:0]  i_addr,
  input wire        i_btn_soil_down,
  input wire        i_btn_soil_up,
  input wire        i_lid_open,
  input wire        i_imbalance_switch,
  input wire [7:0]  i_temp_c,
  input wire        i_cycle_end,
  input wire        i_hot_fill,
  input wire        i_final_rinse,
  // Watched outputs
  input wire [15:0] o_rdata,
  input wire [7:0]  o_valve_count,
  input wire        o_pump_drive,
  input wire        o_cold_valve,
  input wire        o_hot_valve,
  input wire [10:0] o_max_rpm,
  input wire        o_rerun_cycle
);
  reg [7:0]  cnt_q_r;
  reg [31:0] gap_r;
  reg        pump_q_r;
  reg [31:0] pgap_r;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Cycles since countdown or pump drive last moved; reset clears so no stale gap
  always @(posedge i_clk) begin
    cnt_q_r  <= o_valve_count;
    pump_q_r <= o_pump_drive;
    gap_r    <= (i_rst || o_valve_count != cnt_q_r) ? 32'h0 : gap_r + 32'h1;
    pgap_r   <= (i_rst || o_pump_drive != pump_q_r) ? 32'h0 : pgap_r + 32'h1;
  end
  a_status_live: assert property (
    $past(i_rd) && $past(i_addr) == 4'h2 |-> o_rdata == {6'h0, $past(i_imbalance_switch),
    $past(i_lid_open), $past(i_temp_c)}) else $error("status read wrong");
  a_cold_on_down: assert property (
    o_cold_valve |-> $past(i_btn_soil_down) || $past(i_btn_soil_down, 3))
    else $error("cold valve without button");
  a_hot_on_up: assert property (
    o_hot_valve |-> $past(i_btn_soil_up) || $past(i_btn_soil_up, 3))
    else $error("hot valve without button");
  a_count_ceiling: assert property (o_valve_count <= 8'd180)
    else $error("countdown above ceiling");
  // First step after a load may follow a free-running tick, so it is skipped
  a_count_per_sec: assert property (
    $changed(o_valve_count) && o_valve_count == $past(o_valve_count) - 8'h1 &&
    $past(o_valve_count) != 8'd60 && $past(o_valve_count) != 8'd180
    |-> gap_r == SEC_CYC - 1) else $error("countdown step not one second");
  a_pump_half: assert property (
    $rose(o_pump_drive) && pgap_r < 4 * PUMP_HALF |-> pgap_r == PUMP_HALF - 1)
    else $error("pump drive half period wrong");
  a_warm_limit: assert property (
    i_hot_fill && !i_final_rinse |-> ##[1:3] o_max_rpm == 11'd700)
    else $error("spin not limited after hot fill");
  a_warm_clear: assert property (
    i_final_rinse && !i_hot_fill |-> ##[1:3] o_max_rpm == 11'd1000)
    else $error("spin limit not cleared by rinse");
  a_rerun_cause: assert property (
    $rose(o_rerun_cycle) |-> $past(i_cycle_end) || $past(i_cycle_end, 2))
    else $error("rerun without cycle end");
endmodule // sdc_chk

bind sdc_ctrl sdc_chk #(.SEC_CYC(SEC_CYC), .PUMP_HALF(PUMP_HALF)) u_chk (
  .i_clk, .i_rst, .i_rd, .i_addr, .i_btn_soil_down, .i_btn_soil_up, .i_lid_open,
  .i_imbalance_switch, .i_temp_c, .i_cycle_end, .i_hot_fill, .i_final_rinse, .o_rdata,
  .o_valve_count, .o_pump_drive, .o_cold_valve, .o_hot_valve, .o_max_rpm, .o_rerun_cycle);

//--- sdc_panel.sv
// Front panel model: a technician pressing and holding buttons
`timescale 1ns/1ns
// ==========================================
// Panel
module sdc_panel (
  // Clock
  input  wire       i_clk,
  // Levels: side[3:0], up, down, option, eco, fabric, power
  output reg  [9:0] o_btn
);
  initial o_btn = 10'h0;
  // Hold or let go of one button just after an edge
  task hold(input integer b, input bit v);
    @(posedge i_clk);
    o_btn[b] <= v;
  endtask
  // Press long enough for the edge detector, then settle
  task push(input integer b);
    hold(b, 1'b1);
    repeat (4) @(posedge i_clk);
    o_btn[b] <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
endmodule // sdc_panel

//--- service_diagnostic_controller_tb.sv
// Self-checking testbench for the service diagnostic controller
`timescale 1ns/1ns
`include "sdc_map.vh"
// ==========================================
// Bench
module service_diagnostic_controller_tb;
  localparam SEC = 100;
  localparam B_PWR = 0, B_FAB = 1, B_ECO = 2, B_OPT = 3, B_DN = 4, B_UP = 5, B_S0 = 6;
  reg         i_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg         i_lid_open = 1'b1;
  reg         i_imbalance_switch = 1'b0;
  reg  [7:0]  i_temp_c = 8'h16;
  reg  [7:0]  i_fault_code = 8'h0;
  reg  [4:0]  ev = 5'h0;
  reg  [3:0]  i_addr = 4'h0;
  reg  [15:0] i_wdata = 16'h0;
  reg         i_wr = 1'b0;
  reg         i_rd = 1'b0;
  wire [2:0]  i_cycle_phase = 3'h3;
  wire        i_nv_size_ok = 1'b0;
  wire [2:0]  i_nv_size = 3'h0;
  reg  [1:0]  i_nv_flags = 2'h1;
  wire [9:0]  btn;
  wire [15:0] o_rdata;
  wire [2:0]  o_screen, o_size_val;
  wire [7:0]  o_valve_count, o_shown_fault;
  wire [3:0]  o_select_hl;
  wire [4:0]  o_soil_leds, o_fabric_leds;
  wire [10:0] o_max_rpm;
  wire [1:0]  o_nv_flags;
  wire        o_valve_heating, o_valve_cooling, o_pump_drive, o_cold_valve, o_hot_valve;
  wire        o_recirc_valve, o_beep, o_rerun_cycle, o_restart_req, o_nv_store, o_size_store;
  // Panel levels and one-cycle events fanned out to the design pins
  wire i_btn_power = btn[0], i_btn_fabric = btn[1], i_btn_eco_cycle = btn[2];
  wire i_btn_option = btn[3], i_btn_soil_down = btn[4], i_btn_soil_up = btn[5];
  wire [3:0] i_btn_side = btn[9:6];
  wire i_fault_det = ev[0], i_fault_clr = ev[1], i_cycle_end = ev[2];
  wire i_hot_fill = ev[3], i_final_rinse = ev[4];
  wire [4:0] pul = {o_nv_store, 1'b0, o_size_store, o_restart_req, o_rerun_cycle};
  integer failures = 0;
  integer checks = 0;
  reg [15:0] d;
  integer n, z;
  sdc_panel panel (.i_clk(i_clk), .o_btn(btn));
  sdc_ctrl #(.SEC_CYC(SEC), .MS_CYC(10), .PUMP_HALF(5)) DUT (.*);
  // Clock, 100 MHz
  always #5 i_clk = ~i_clk;
  // ==========================================
  // Helpers
  task chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task step(input integer c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task pulse(input integer k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    @(posedge i_clk);
    ev[k] <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task wr(input [3:0] a, input [15:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Cycles in which pulse output k stands high, or toggles of the pump drive
  task seen(input integer k, input integer c);
    reg p;
    n = 0;
    p = o_pump_drive;
    repeat (c) begin
      #1;
      if (k != 3 && pul[k] === 1'b1) n++;
      if (k == 3 && o_pump_drive !== p) n++;
      p = o_pump_drive;
      @(posedge i_clk);
    end
  endtask
  // ==========================================
  // Scenarios
  task t_enter_diag;
    reg b;
    panel.hold(B_ECO, 1'b1);
    panel.push(B_PWR);
    panel.hold(B_ECO, 1'b0);
    n = 0;
    b = 1'b0;
    repeat (6000) begin
      @(posedge i_clk);
      #1;
      if (o_beep === 1'b1 && !b) n++;
      b = (o_beep === 1'b1);
    end
    chk(n == 2, "beep count");
    chk(o_screen === `SDC_SCR_BLANK, "screen not blank");
  endtask
  task t_status;
    panel.push(B_ECO);
    chk(o_screen === `SDC_SCR_MACHINE, "no machine screen");
    rd(`SDC_REG_STATUS);
    chk(d === 16'h0116, "status closed");
    @(posedge i_clk);
    i_lid_open <= 1'b0;
    i_imbalance_switch <= 1'b1;
    i_temp_c <= 8'h2d;
    rd(`SDC_REG_STATUS);
    chk(d === 16'h022d, "status live");
    wr(`SDC_REG_CTRL, 16'hffff);
    rd(`SDC_REG_CTRL);
    chk(d === 16'h0001, "write not ignored");
    rd(4'hf);
    chk(d === 16'h0000, "unmapped read");
  endtask
  task t_recirc;
    panel.push(B_S0 + 3);
    chk(o_valve_heating === 1'b1 && o_valve_count inside {8'd59, 8'd60}, "heat");
    step(SEC * 55);
    chk(o_valve_heating === 1'b1, "heat short");
    step(SEC * 6);
    chk(!o_valve_heating && o_valve_count === 8'd0 && o_recirc_valve, "on");
    panel.push(B_ECO); // side press left the machine screen
    panel.push(B_S0 + 3);
    chk(o_valve_cooling === 1'b1 && o_valve_count inside {8'd179, 8'd180}, "cool");
    step(SEC * 175);
    chk(o_valve_cooling === 1'b1, "cool short");
    step(SEC * 7);
    chk(!o_valve_cooling && o_valve_count === 8'd0 && !o_recirc_valve, "off");
  endtask
  task t_pump;
    panel.push(B_FAB);
    seen(3, 1200);
    chk(n >= 230, "pump not at 50 Hz");
    panel.push(B_FAB);
    seen(3, 50);
    chk(n == 0, "pump not stopped");
  endtask
  task t_valves;
    panel.hold(B_DN, 1'b1);
    step(4);
    chk(o_cold_valve === 1'b1 && o_hot_valve === 1'b0, "cold");
    panel.hold(B_DN, 1'b0);
    panel.hold(B_UP, 1'b1);
    step(4);
    chk(o_cold_valve === 1'b0 && o_hot_valve === 1'b1, "hot");
    panel.hold(B_UP, 1'b0);
    step(4);
    chk(o_hot_valve === 1'b0, "hot stays");
  endtask
  task t_option;
    panel.push(B_OPT);
    chk(o_screen === `SDC_SCR_OPTION, "no option screen");
    chk(o_select_hl === 4'b0001, "retry not lit");
    panel.push(B_S0);
    rd(`SDC_REG_CTRL);
    chk(d === 16'h0000 && o_select_hl === 4'b0000, "retry off");
    i_fault_code <= 8'h42;
    pulse(0);
    step(3);
    chk(o_shown_fault === 8'h42 && o_beep === 1'b1, "fault late");
    pulse(1);
    panel.push(B_S0);
    chk(o_select_hl === 4'b0001, "retry on");
    i_fault_code <= 8'h55;
    pulse(0);
    seen(1, SEC + 10);
    chk(n >= 1 && o_shown_fault !== 8'h55, "no restart");
    pulse(1);
    panel.push(B_S0);
    t_valves;
  endtask
  task t_repeat_warm;
    panel.push(B_S0 + 1);
    pulse(2);
    seen(0, 4);
    chk(n == 1, "no rerun");
    panel.push(B_S0 + 1);
    pulse(2);
    seen(0, 4);
    chk(n == 0, "rerun when off");
    panel.push(B_S0 + 1);
    pulse(3);
    step(3);
    rd(`SDC_REG_CTRL);
    chk(o_max_rpm === `SDC_RPM_WARM && d === 16'h0006, "warm");
    panel.push(B_S0 + 2);
    chk(o_max_rpm === `SDC_RPM_FULL, "clear select");
    pulse(3);
    pulse(4);
    step(3);
    chk(o_max_rpm === `SDC_RPM_FULL, "clear rinse");
  endtask
  // Retry off and repeat on are stored, then reloaded at power-on: both LED rows flash
  task t_normal;
    panel.push(B_ECO);
    panel.hold(B_S0, 1'b1);
    seen(4, 20100);
    panel.hold(B_S0, 1'b0);
    chk(n == 1 && o_nv_flags === 2'h2, "flags not stored");
    panel.push(B_PWR);
    i_nv_flags <= 2'h2;
    panel.push(B_PWR);
    step(20);
    chk(o_screen === `SDC_SCR_NORMAL, "no run");
    chk(o_shown_fault === `SDC_FAULT_NOSIZE, "no size fault");
    n = 0;
    z = 0;
    repeat (11000) begin
      @(posedge i_clk);
      #1;
      if (o_soil_leds === 5'h1f && o_fabric_leds === 5'h1f) n++;
      if (o_soil_leds === 5'h00 && o_fabric_leds === 5'h00) z++;
    end
    chk(n > 0 && z > 0, "leds not flashing");
    panel.push(B_PWR);
  endtask
  task t_size;
    panel.hold(B_FAB, 1'b1);
    panel.push(B_PWR);
    panel.hold(B_FAB, 1'b0);
    step(4);
    chk(o_screen === `SDC_SCR_SIZE, "no size setup");
    panel.push(B_S0 + 1);
    chk(o_select_hl === 4'b0100, "size not lit");
    panel.hold(B_PWR, 1'b1);
    seen(2, 10);
    panel.hold(B_PWR, 1'b0);
    chk(n == 1 && o_size_val === 3'h2, "size not stored");
  endtask
  // ==========================================
  // Closing
  task results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog, well past the expected run of some 64000 cycles
  initial begin
    #900000;
    failures++;
    results;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_enter_diag;
    t_status;
    t_recirc;
    t_pump;
    t_option;
    t_repeat_warm;
    t_normal;
    t_size;
    results;
  end
endmodule // service_diagnostic_controller_tb
